// ### hdl/cgp_div.sv
// One programmable high/low counter of the PLL divider chain.
`timescale 1ns/1ps
module cgp_div (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick_i,
   input wire logic lvl_i,
   input wire logic bypass_i,
   input wire logic inv_i,
   input wire logic [7:0] hi_i,
   input wire logic [7:0] lo_i,
   output logic lvl_o,
   output logic tick_o
);
   import cgp_pkg::*;

   // -----------------------------------------------------------------
   // Count state
   // -----------------------------------------------------------------
   logic [8:0] cnt_r;     // Input edges seen in the current phase.
   logic high_r;          // Set while in the high phase.
   logic [8:0] len;       // Length of the current phase.

   // The phase length switches between high and low count.
   always_comb begin
      len = high_r ? cgp_len(hi_i) : cgp_len(lo_i);
   end

   // Ratio is high plus low count; duty steps by one input edge.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= 9'h000;
         high_r <= 1'b0;
         lvl_o <= 1'b0;
         tick_o <= 1'b0;
      end else if (bypass_i) begin
         // Divide by one: the input passes on a cycle later.
         cnt_r <= 9'h000;
         high_r <= 1'b0;
         lvl_o <= lvl_i ^ inv_i;
         tick_o <= tick_i;
      end else begin
         tick_o <= 1'b0;
         if (tick_i) begin
            if (cnt_r + 9'h001 >= len) begin
               // Phase ends, so the output flips.
               cnt_r <= 9'h000;
               high_r <= ~high_r;
               lvl_o <= ~high_r ^ inv_i;
               tick_o <= ~high_r;
            end else begin
               cnt_r <= cnt_r + 9'h001;
            end
         end
      end
   end

endmodule : cgp_div

// ### hdl/cgp_pkg.sv
// Constants, register map and helpers of the clock gate and PLL divider block.
package cgp_pkg;

   // -----------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int NUM_NET = 4;         // Global and regional networks.
   localparam int NUM_EXT = 2;         // Dedicated external clock pins.
   localparam int NUM_CH = 6;          // Networks plus external pins.
   localparam int NUM_C = 4;           // Post-scale output counters.
   localparam int NUM_DIV = 6;         // Pre-scale, feedback, C0..C3.
   localparam int FB_PIN = 1;          // External pin reused as fbin.

   // -----------------------------------------------------------------
   // Register offsets (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_NDIV = 8'h04;
   localparam logic [7:0] ADDR_MDIV = 8'h08;
   localparam logic [7:0] ADDR_C0 = 8'h10;
   localparam logic [7:0] ADDR_STAT = 8'h20;
   localparam logic [2:0] IDX_N = 3'h0;
   localparam logic [2:0] IDX_M = 3'h1;
   localparam logic [2:0] IDX_C0 = 3'h2;
   localparam logic [2:0] IDX_NONE = 3'h7;

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int F_HI = 0;            // High-time count, 0 means 256.
   localparam int F_LO = 8;            // Low-time count, 0 means 256.
   localparam int F_BYP = 16;          // Counter bypass, divide by one.
   localparam int F_INV = 17;          // Inverts the output of C0..C3 only.
   localparam int C_KEN = 0;           // VCO halving counter enable.
   localparam int C_EXT_FB = 1;        // External feedback mode.
   localparam int C_SYNC_BYP = 2;      // Bypass metastability stage.
   localparam int C_SRC = 8;           // Fabric source per network.
   localparam int S_LOCK = 0;
   localparam int S_EXT_FB = 1;
   localparam int S_GATE = 8;
   localparam logic [31:0] RST_CTRL = 32'h0000_0001;
   localparam logic [31:0] RST_DIV = 32'h0000_0101;
   localparam logic [7:0] K_HALF = 8'h01;
   localparam logic [2:0] LOCK_PERIODS = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Loop lock tracker states, Gray coded along the acquire path.
   typedef enum logic [1:0] {
      LK_IDLE = 2'b00,
      LK_ACQ = 2'b01,
      LK_LOCKED = 2'b11
   } cgp_lock_t;

   // Turns an 8-bit count field into its value of 1 to 256.
   function automatic logic [8:0] cgp_len(input logic [7:0] f);
      cgp_len = (f == 8'h00) ? 9'h100 : {1'b0, f};
   endfunction : cgp_len

   // Maps a byte address to a divider index, or IDX_NONE.
   function automatic logic [2:0] cgp_div_idx(input logic [7:0] a);
      if (a == ADDR_NDIV) cgp_div_idx = IDX_N;
      else if (a == ADDR_MDIV) cgp_div_idx = IDX_M;
      else if (a[7:4] == ADDR_C0[7:4] && a[1:0] == 2'h0)
         cgp_div_idx = IDX_C0 + {1'b0, a[3:2]};
      else cgp_div_idx = IDX_NONE;
   endfunction : cgp_div_idx

   // Merges write data into a word under the byte strobes.
   function automatic logic [31:0] cgp_merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         cgp_merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
      end
   endfunction : cgp_merge

endpackage : cgp_pkg

// ### hdl/cgp_top.sv
// Clock network gating and PLL divider chain with an AXI4-Lite register port.
`timescale 1ns/1ps
module cgp_top #(
   parameter bit IS_CORNER = 1'b0      // Corner fractional PLL instance.
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [cgp_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [cgp_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [cgp_pkg::NUM_CH-1:0] clk_en_i,
   input wire logic [cgp_pkg::NUM_NET-1:0] net_src_i,
   input wire logic fb_in_i,
   output logic [cgp_pkg::NUM_NET-1:0] net_clk_o,
   output logic [cgp_pkg::NUM_EXT-1:0] ext_clk_o,
   output logic [cgp_pkg::NUM_EXT-1:0] ext_clk_oe_o,
   output logic fb_out_o,
   output logic locked_o
);
   import cgp_pkg::*;

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic [31:0] ctrl_r;                // Mode and source selects.
   logic [31:0] div_r [NUM_DIV];       // Divider settings by index.
   logic aw_have_r;                    // Write address held.
   logic w_have_r;                     // Write data held.
   logic [7:0] waddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_go;                        // Both halves present.
   logic [2:0] wr_idx;
   logic [2:0] rd_idx;
   logic [31:0] rd_word;
   logic ext_fb_act;                   // External feedback in force.
   logic relock;                       // Loop settings changed.
   logic vco_lvl_r;                    // Model of the VCO output.
   logic n_tick;                       // Reference after pre-scale.
   logic k_lvl, k_tick;                // VCO after halving stage.
   logic m_lvl, m_tick;                // Feedback counter output.
   logic [NUM_C-1:0] c_lvl;            // Post-scale outputs.
   logic fb_in_q_r;
   logic fb_tick;
   logic [1:0] fb_seen_r;              // Feedback edges per ref edge.
   logic [2:0] lock_cnt_r;
   cgp_lock_t lock_r;
   logic [NUM_CH-1:0] src_lvl;         // Ungated clock per channel.
   logic [NUM_CH-1:0] meta_r;          // Metastability stage.
   logic [NUM_CH-1:0] en_q_r;          // Enable in force.

   // -----------------------------------------------------------------
   // AXI4-Lite write channels
   // -----------------------------------------------------------------

   // Address and data are taken in either order and held until the
   // response is accepted, so one write is under way at a time.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         aw_have_r <= 1'b0;
         waddr_r <= 8'h00;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_have_r <= 1'b1;
         waddr_r <= awaddr;
      end else if (bvalid && bready) begin
         awready <= 1'b1;
         aw_have_r <= 1'b0;
      end
   end

   // Write data side, same life cycle as the address.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b1;
         w_have_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_have_r <= 1'b1;
         wdata_r <= wdata;
         wstrb_r <= wstrb;
      end else if (bvalid && bready) begin
         wready <= 1'b1;
         w_have_r <= 1'b0;
      end
   end

   assign wr_go = aw_have_r && w_have_r && !bvalid;
   assign wr_idx = cgp_div_idx(waddr_r);

   // Response; unmapped or read-only offsets answer SLVERR.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         if (waddr_r == ADDR_CTRL || wr_idx != IDX_NONE) begin
            bresp <= RESP_OKAY;
         end else begin
            bresp <= RESP_SLVERR;
         end
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------

   // Control word. The feedback bit cannot be set on a corner PLL,
   // so software reads back what is really in force.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= RST_CTRL;
      end else if (wr_go && waddr_r == ADDR_CTRL) begin
         ctrl_r <= cgp_merge(ctrl_r, wdata_r, wstrb_r);
         if (IS_CORNER) begin
            ctrl_r[C_EXT_FB] <= 1'b0;
         end
      end
   end

   // Divider settings: every counter has high and low fields.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_DIV; i++) begin
            div_r[i] <= RST_DIV;
         end
      end else if (wr_go && wr_idx != IDX_NONE) begin
         div_r[wr_idx] <= cgp_merge(div_r[wr_idx], wdata_r, wstrb_r);
      end
   end

   // A change to the loop settings restarts lock tracking. Enable
   // changes are not in this list, so gating never drops lock.
   assign relock = wr_go && (wr_idx == IDX_N || wr_idx == IDX_M ||
                             waddr_r == ADDR_CTRL);

   // -----------------------------------------------------------------
   // AXI4-Lite read channels
   // -----------------------------------------------------------------
   assign rd_idx = cgp_div_idx(araddr);

   // Read mux; status shows lock, feedback mode and gate state.
   always_comb begin
      rd_word = 32'h0000_0000;
      if (araddr == ADDR_CTRL) begin
         rd_word = ctrl_r;
      end else if (araddr == ADDR_STAT) begin
         rd_word[S_LOCK] = (lock_r == LK_LOCKED);
         rd_word[S_EXT_FB] = ext_fb_act;
         rd_word[S_GATE +: NUM_CH] = en_q_r;
      end else if (rd_idx != IDX_NONE) begin
         rd_word = div_r[rd_idx];
      end
   end

   // The answer is registered and held until it is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_word;
         if (araddr == ADDR_CTRL || araddr == ADDR_STAT ||
             rd_idx != IDX_NONE) begin
            rresp <= RESP_OKAY;
         end else begin
            rresp <= RESP_SLVERR;
         end
      end else if (rvalid && rready) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Divider chain
   // -----------------------------------------------------------------

   // The VCO is modelled as half the system clock rate.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vco_lvl_r <= 1'b0;
      end else begin
         vco_lvl_r <= ~vco_lvl_r;
      end
   end

   // Pre-scale counter on the reference; its tick alone is used, so
   // its high and low split sets no output duty.
   cgp_div u_ndiv (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick_i(1'b1),
      .lvl_i(1'b0),
      .bypass_i(div_r[IDX_N][F_BYP]),
      .inv_i(1'b0),
      .hi_i(div_r[IDX_N][F_HI +: 8]),
      .lo_i(div_r[IDX_N][F_LO +: 8]),
      .lvl_o(),
      .tick_o(n_tick)
   );

   // Halving counter: fixed one and one, or bypassed.
   cgp_div u_kdiv (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick_i(~vco_lvl_r),
      .lvl_i(vco_lvl_r),
      .bypass_i(~ctrl_r[C_KEN]),
      .inv_i(1'b0),
      .hi_i(K_HALF),
      .lo_i(K_HALF),
      .lvl_o(k_lvl),
      .tick_o(k_tick)
   );

   // Feedback multiply counter, fed from the halving stage.
   cgp_div u_mdiv (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick_i(k_tick),
      .lvl_i(k_lvl),
      .bypass_i(div_r[IDX_M][F_BYP]),
      .inv_i(1'b0),
      .hi_i(div_r[IDX_M][F_HI +: 8]),
      .lo_i(div_r[IDX_M][F_LO +: 8]),
      .lvl_o(m_lvl),
      .tick_o(m_tick)
   );

   // One post-scale counter per network; the external pins reuse C0 and C1. Equal high and low give
   // 50% duty; one count of either moves duty by one input period, a step
   // of one over the divide value.
   for (genvar g = 0; g < NUM_C; g++) begin : g_cdiv
      cgp_div u_cdiv (
         .aclk(aclk),
         .aresetn(aresetn),
         .tick_i(k_tick),
         .lvl_i(k_lvl),
         .bypass_i(div_r[IDX_C0 + g][F_BYP]),
         .inv_i(div_r[IDX_C0 + g][F_INV]),
         .hi_i(div_r[IDX_C0 + g][F_HI +: 8]),
         .lo_i(div_r[IDX_C0 + g][F_LO +: 8]),
         .lvl_o(c_lvl[g]),
         .tick_o()
      );
   end

   // -----------------------------------------------------------------
   // Feedback path and lock tracking
   // -----------------------------------------------------------------
   assign ext_fb_act = ctrl_r[C_EXT_FB] && !IS_CORNER;

   // Feedback pin input is synchronous; keep last level for edges.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fb_in_q_r <= 1'b0;
      end else begin
         fb_in_q_r <= fb_in_i;
      end
   end

   // In external mode the loop closes through the board trace.
   assign fb_tick = ext_fb_act ? (fb_in_i && !fb_in_q_r) : m_tick;

   // Counts feedback edges between reference edges, saturating.
   always_ff @(posedge aclk) begin
      if (!aresetn || relock) begin
         fb_seen_r <= 2'h0;
      end else if (n_tick) begin
         fb_seen_r <= {1'b0, fb_tick};
      end else if (fb_tick && fb_seen_r != 2'h3) begin
         fb_seen_r <= fb_seen_r + 2'h1;
      end
   end

   // Lock after several reference periods with exactly one feedback
   // edge each. This is a frequency check only; phase is not judged.
   always_ff @(posedge aclk) begin
      if (!aresetn || relock) begin
         lock_r <= LK_IDLE;
         lock_cnt_r <= 3'h0;
      end else if (n_tick) begin
         case (lock_r)
            LK_IDLE: begin
               if (fb_seen_r == 2'h1) begin
                  lock_r <= LK_ACQ;
                  lock_cnt_r <= 3'h1;
               end
            end
            LK_ACQ: begin
               if (fb_seen_r != 2'h1) begin
                  lock_r <= LK_IDLE;
               end else if (lock_cnt_r + 3'h1 >= LOCK_PERIODS) begin
                  lock_r <= LK_LOCKED;
               end else begin
                  lock_cnt_r <= lock_cnt_r + 3'h1;
               end
            end
            LK_LOCKED: begin
               if (fb_seen_r != 2'h1) begin
                  lock_r <= LK_IDLE;
               end
            end
            default: begin
               lock_r <= LK_IDLE;
            end
         endcase
      end
   end

   // Lock and feedback outputs are registered copies.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         locked_o <= 1'b0;
         fb_out_o <= 1'b0;
      end else begin
         locked_o <= (lock_r == LK_LOCKED);
         fb_out_o <= m_lvl;
      end
   end

   // -----------------------------------------------------------------
   // Clock gating
   // -----------------------------------------------------------------

   // Networks take a post-scale output or a fabric clock, so a
   // network can be gated with no PLL in use at all.
   always_comb begin
      for (int i = 0; i < NUM_NET; i++) begin
         src_lvl[i] = ctrl_r[C_SRC + i] ? net_src_i[i] : c_lvl[i];
      end
      for (int j = 0; j < NUM_EXT; j++) begin
         src_lvl[NUM_NET + j] = c_lvl[j];
      end
   end

   // The stage catches a raw request; the enable in force updates
   // only while the source clock is low, sampled at the rising aclk
   // edge. A high pulse therefore always runs to full width.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         en_q_r <= '0;
      end else begin
         meta_r <= clk_en_i;
         for (int i = 0; i < NUM_CH; i++) begin
            if (!src_lvl[i]) begin
               en_q_r[i] <= ctrl_r[C_SYNC_BYP] ? clk_en_i[i] : meta_r[i];
            end
         end
      end
   end

   // Gated outputs sit low while off. Counters keep running behind
   // the gate, so lock is unaffected by any enable.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         net_clk_o <= '0;
         ext_clk_o <= '0;
         ext_clk_oe_o <= '0;
      end else begin
         net_clk_o <= src_lvl[NUM_NET-1:0] & en_q_r[NUM_NET-1:0];
         for (int j = 0; j < NUM_EXT; j++) begin
            // The shared pin stops driving and serves as fbin.
            if (ext_fb_act && j == FB_PIN) begin
               ext_clk_o[j] <= 1'b0;
               ext_clk_oe_o[j] <= 1'b0;
            end else begin
               ext_clk_o[j] <= src_lvl[NUM_NET + j] & en_q_r[NUM_NET + j];
               ext_clk_oe_o[j] <= 1'b1;
            end
         end
      end
   end

endmodule : cgp_top

// ### tb/cgp_fabric_model.sv
// Fabric logic that drives clock enables, fabric clocks and the feedback trace.
`timescale 1ns/1ps
module cgp_fabric_model (
   input wire logic aclk,
   input wire logic [5:0] en_req,
   input wire logic fb_out,
   output logic [5:0] clk_en,
   output logic [3:0] net_src,
   output logic fb_in
);
   initial begin
      clk_en = 6'h00;
      net_src = 4'h0;
      fb_in = 1'b0;
   end
   // Enables move just after an edge, like any fabric flop, so gating
   // must cope with changes at any point of the gated clock.
   always @(posedge aclk) begin
      clk_en <= en_req;
      net_src <= net_src + 4'h1; // Network i toggles every 2^i cycles.
      fb_in <= fb_out; // Board trace back to the feedback pin.
   end
endmodule : cgp_fabric_model

// ### tb/cgp_sva.sv
// Bus and lock checks bound to the clock gate top.
`timescale 1ns/1ps
module cgp_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic locked_o
);
   import cgp_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Answers must stand until the master takes them.
   chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
      else $error("read response dropped early");
   chk_w_busy: assert property (bvalid |-> !awready && !wready)
      else $error("write slot open while response pending");
   chk_r_busy: assert property (rvalid |-> !arready)
      else $error("read slot open while data pending");
   chk_w_lat: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
      else $error("write response not two edges after take");
   chk_r_lat: assert property (arvalid && arready |=> rvalid)
      else $error("read data not one edge after take");
   // A hole in the map answers with an error and zero data.
   chk_hole_read: assert property (arvalid && arready && araddr == 8'h0C |=>
      rresp == RESP_SLVERR && rdata == 32'h0) else $error("unmapped read not refused");
   // Only a register write may drop lock; gating never does.
   chk_lock_kept: assert property (locked_o && awready && !awvalid |=> locked_o)
      else $error("lock lost without a write");
endmodule : cgp_sva

bind cgp_top cgp_sva i_sva (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
   .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
   .rready, .locked_o);

// ### tb/tb_cgp_top.sv
// Self-checking bench for the clock gate and PLL divider block.
`timescale 1ns/1ps
module tb_cgp_top;
   import cgp_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [5:0] en_req = 6'h00, clk_en;
   logic [3:0] net_src, net_clk;
   logic fb_in, fb_out, locked, awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, ext_clk, ext_oe;
   int error_cnt = 0, checks_done = 0, cyc = 0;
   always #5 aclk = ~aclk;
   cgp_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .clk_en_i(clk_en), .net_src_i(net_src), .fb_in_i(fb_in),
      .net_clk_o(net_clk), .ext_clk_o(ext_clk), .ext_clk_oe_o(ext_oe),
      .fb_out_o(fb_out), .locked_o(locked));
   cgp_fabric_model i_fab (.aclk, .en_req, .fb_out, .clk_en, .net_src, .fb_in);
   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   // Bus tasks hold each channel until taken; bready and rready come late on purpose.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 0;
      w = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (awvalid && awready) begin aw = 1; awvalid <= 1'b0; end
         if (wvalid && wready) begin w = 1; wvalid <= 1'b0; end
      end
      repeat (2) @(posedge aclk);
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(32'(bresp), 32'(er));
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
      input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata & m, e);
      chk(32'(rresp), 32'(er));
   endtask : axi_rd
   task automatic to_lvl(input logic v);
      while (fb_out !== v) @(posedge aclk);
   endtask : to_lvl
   // Programs the feedback counter and times one whole high and low phase.
   task automatic fb_len(input logic [31:0] ctl, input logic [31:0] m, input int h, input int l);
      int n;
      axi_wr(ADDR_CTRL, ctl, RESP_OKAY);
      axi_wr(ADDR_MDIV, m, RESP_OKAY);
      to_lvl(0); to_lvl(1); to_lvl(0); to_lvl(1);
      for (n = 0; fb_out === 1'b1; n++) @(posedge aclk);
      chk(n, h);
      for (n = 0; fb_out === 1'b0; n++) @(posedge aclk);
      chk(n, l);
   endtask : fb_len
   // Each gated network must copy its source one cycle later.
   task automatic follow(input int n);
      logic [3:0] s;
      repeat (n) begin
         s = net_src;
         @(posedge aclk);
         chk(32'(net_clk), 32'(s));
      end
   endtask : follow
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_regs;
      axi_rd(ADDR_CTRL, RST_CTRL, '1, RESP_OKAY);
      axi_rd(ADDR_NDIV, RST_DIV, '1, RESP_OKAY);
      axi_rd(8'h1C, RST_DIV, '1, RESP_OKAY);
      axi_rd(8'h0C, 32'h0, '1, RESP_SLVERR);
      axi_wr(ADDR_STAT, 32'hFFFF, RESP_SLVERR);
      axi_wr(8'h0C, 32'h1, RESP_SLVERR);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_div;
      fb_len(32'h0F04, 32'h0503, 6, 10);
      fb_len(32'h0F05, 32'h0503, 12, 20);
      fb_len(32'h0F04, 32'h0100, 512, 2);
      $display("t_div done");
   endtask : t_div
   task automatic t_gate;
      axi_wr(ADDR_CTRL, 32'h0F05, RESP_OKAY);
      en_req <= 6'h3F;
      repeat (20) @(posedge aclk);
      follow(16);
      while (net_src[3] !== 1'b0) @(posedge aclk);
      while (net_src[3] !== 1'b1) @(posedge aclk);
      en_req <= 6'h00;
      repeat (8) begin @(posedge aclk); chk(32'(net_clk[3]), 32'h1); end
      repeat (10) @(posedge aclk);
      repeat (16) begin @(posedge aclk); chk(32'({ext_clk, net_clk}), 32'h0); end
      axi_wr(ADDR_CTRL, 32'h0F01, RESP_OKAY);
      en_req <= 6'h3F;
      repeat (20) @(posedge aclk);
      follow(16);
      $display("t_gate done");
   endtask : t_gate
   task automatic t_lock;
      int n;
      axi_wr(ADDR_NDIV, 32'h0404, RESP_OKAY); // Reference period 8 matches feedback.
      axi_wr(ADDR_MDIV, RST_DIV, RESP_OKAY);
      axi_wr(ADDR_CTRL, 32'h0F05, RESP_OKAY);
      for (n = 0; n < 3000 && locked !== 1'b1; n++) @(posedge aclk);
      en_req <= 6'h00;
      repeat (40) @(posedge aclk);
      en_req <= 6'h3F;
      repeat (40) @(posedge aclk);
      chk(32'(locked), 32'h1);
      axi_wr(ADDR_CTRL, 32'h0F07, RESP_OKAY);
      axi_rd(ADDR_STAT, 32'h2, 32'h2, RESP_OKAY);
      chk(32'(ext_oe[FB_PIN]), 32'h0);
      $display("t_lock done");
   endtask : t_lock
   // Hang guard, well above the few thousand cycles the scenarios need.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_div;
      t_gate;
      t_lock;
      tally_and_finish;
   end
endmodule : tb_cgp_top
